// [bench/eep_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// two-wire bus controller, paced from the falling edges of the system clock
module eep_ctl_model (
  input  wire logic clk,
  input  wire logic dev_oe,
  output logic      scl,
  output wire logic sda
);
  logic pull_low = 1'b0;

  // open drain with pull-up: the wire is low if either party pulls
  assign sda = ~(pull_low | dev_oe);

  // clock stands high outside frames
  initial scl = 1'b1;

  task automatic hp(input int n);
    repeat (n) @(negedge clk);
  endtask : hp

  // data moves only while the clock is low, one pulse per bit
  task automatic bit_io(input logic v, output logic s);
    pull_low = ~v;
    hp(2);
    scl = 1'b1;
    hp(3);
    s = sda;
    hp(1);
    scl = 1'b0;
    hp(2);
  endtask : bit_io

  // also the recovery path: a start resets the target mid-frame
  task automatic start;
    pull_low = 1'b0;
    hp(4);
    scl = 1'b1;
    hp(4);
    pull_low = 1'b1;
    hp(4);
    scl = 1'b0;
    hp(2);
  endtask : start

  // stuck bus: pulse the clock until data reads high, at most nine times
  task automatic recover(output int n);
    logic s;
    n = 0;
    s = 1'b0;
    while (!s && n < 9)
    begin
      bit_io(1'b1, s);
      n++;
    end
    start();
  endtask : recover

  task automatic stop;
    pull_low = 1'b1;
    hp(2);
    scl = 1'b1;
    hp(4);
    pull_low = 1'b0;
    hp(4);
  endtask : stop

  // msb first; the ninth pulse carries the target's answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte

  // controller acks every byte but the last to keep a read going
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask : rbyte
endmodule : eep_ctl_model
`default_nettype wire

// [bench/eep_target_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module eep_target_bench;
  // short programming time keeps the run brief; still longer than one poll
  localparam int WRC = 300;
  typedef struct packed {logic hi; logic lo; logic [7:0] adr; logic ack;} eep_row_t;
  eep_row_t   rows [10] = '{
    '{1'b0, 1'b0, 8'ha0, 1'b1}, '{1'b0, 1'b0, 8'hb0, 1'b1}, '{1'b0, 1'b0, 8'h90, 1'b0},
    '{1'b0, 1'b0, 8'ha2, 1'b1}, '{1'b1, 1'b0, 8'ha8, 1'b1}, '{1'b1, 1'b0, 8'ha0, 1'b0},
    '{1'b0, 1'b1, 8'ha4, 1'b1}, '{1'b1, 1'b1, 8'hac, 1'b1}, '{1'b1, 1'b1, 8'ha8, 1'b0},
    '{1'b0, 1'b0, 8'he0, 1'b0}};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wp = 1'b0;
  logic       s_hi = 1'b0;
  logic       s_lo = 1'b0;
  logic [7:0] mem [16];
  logic       a;
  int         fails = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         t0;
  int         n;
  wire logic  scl, sda, oe, sdo, stby, busy;

  always #4 clk = ~clk;

  // free cycle count for timing the programming window
  always @(posedge clk) cyc++;

  eep_target #(.WR_CYCLES(WRC)) u_dut (.SYS_CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sdo), .SDA_OE(oe), .WP(wp), .ADDRESS_STRAP_LOW(s_lo),
    .ADDRESS_STRAP_HIGH(s_hi), .STANDBY(stby), .WRITE_BUSY(busy));
  eep_ctl_model u_ctl (.clk(clk), .dev_oe(oe), .scl(scl), .sda(sda));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic [7:0] b, input logic ea);
    logic k;
    u_ctl.wbyte(b, k);
    chk("ack", {7'h0, k}, {7'h0, ea});
  endtask : wb

  // dummy write sets the pointer, then a repeated start turns to reading
  task automatic seek(input logic [7:0] dev, input logic [7:0] wa);
    u_ctl.start();
    wb(dev, 1'b1);
    wb(wa, 1'b1);
    u_ctl.start();
    wb(dev | 8'h01, 1'b1);
  endtask : seek

  task automatic rdb(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    u_ctl.rbyte(last, d);
    chk("rdata", d, exp);
  endtask : rdb

  // stop must launch programming; its length follows the parameter
  task automatic prog;
    u_ctl.stop();
    t0 = cyc;
    chk("busy_stby", {6'h0, busy, stby}, 8'h02);
    u_ctl.start();
    wb(8'ha0, 1'b0);
    u_ctl.stop();
    while (busy !== 1'b0 && cyc - t0 < WRC + 50) @(negedge clk);
    chk("prog_len", {7'h0, cyc - t0 > WRC - 12 && cyc - t0 <= WRC}, 8'h01);
    chk("standby", {7'h0, stby}, 8'h01);
  endtask : prog

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // watchdog sized well above the expected run length
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    test_done();
  end

  initial
  begin
    for (int k = 0; k < 18; k++) mem[(14 + k) % 16] = 8'h40 + 8'(k);
    repeat (19) @(negedge clk);
    chk("rst_out", {4'h0, stby, busy, oe, sdo}, 8'h08);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (rows[i])
    begin
      s_hi = rows[i].hi;
      s_lo = rows[i].lo;
      u_ctl.start();
      wb(rows[i].adr, rows[i].ack);
      u_ctl.stop();
    end
    s_hi = 1'b0;
    s_lo = 1'b0;
    // an address byte with no start in front is ignored
    u_ctl.wbyte(8'ha0, a);
    chk("no_start", {7'h0, a}, 8'h00);
    u_ctl.stop();
    // 18 bytes from offset 0x1e: wrap in page, last two overwrite
    u_ctl.start();
    wb(8'ha0, 1'b1);
    wb(8'h1e, 1'b1);
    for (int k = 0; k < 18; k++) wb(8'h40 + 8'(k), 1'b1);
    prog();
    seek(8'ha0, 8'h10);
    for (int k = 0; k < 16; k++) rdb(k == 15, mem[k]);
    u_ctl.stop();
    // upper block holds its own byte at the same word address
    u_ctl.start();
    wb(8'ha2, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h5a, 1'b1);
    prog();
    seek(8'ha2, 8'h10);
    rdb(1'b1, 8'h5a);
    u_ctl.stop();
    seek(8'ha0, 8'h10);
    rdb(1'b1, mem[0]);
    u_ctl.stop();
    u_ctl.start();
    wb(8'ha1, 1'b1);
    rdb(1'b1, mem[1]);
    u_ctl.stop();
    // protected write still handshakes, programs nothing
    wp = 1'b1;
    u_ctl.start();
    wb(8'ha0, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'hff, 1'b1);
    u_ctl.stop();
    repeat (4) @(negedge clk);
    chk("wp_busy", {7'h0, busy}, 8'h00);
    wp = 1'b0;
    // a start in mid-write throws the buffered byte away
    u_ctl.start();
    wb(8'ha0, 1'b1);
    wb(8'h11, 1'b1);
    wb(8'h77, 1'b1);
    u_ctl.start();
    wb(8'ha0, 1'b1);
    u_ctl.stop();
    repeat (4) @(negedge clk);
    chk("abort_busy", {7'h0, busy}, 8'h00);
    seek(8'ha0, 8'h10);
    rdb(1'b0, mem[0]);
    rdb(1'b1, mem[1]);
    u_ctl.stop();
    // identification page is kept apart from the array at the same word
    u_ctl.start();
    wb(8'hb0, 1'b1);
    wb(8'h13, 1'b1);
    wb(8'h3c, 1'b1);
    prog();
    seek(8'hb0, 8'h13);
    rdb(1'b1, 8'h3c);
    u_ctl.stop();
    seek(8'ha0, 8'h13);
    rdb(1'b1, mem[3]);
    u_ctl.stop();
    // stuck read: the target holds data low until clocked free
    seek(8'ha0, 8'h10);
    for (int k = 0; k < 7; k++) u_ctl.bit_io(1'b1, a);
    u_ctl.recover(n);
    chk("recover", 8'(n), 8'h02);
    wb(8'ha0, 1'b1);
    u_ctl.stop();
    // reset in mid-run, while programming, must silence and free the target
    u_ctl.start();
    wb(8'ha0, 1'b1);
    wb(8'h12, 1'b1);
    wb(8'h99, 1'b1);
    u_ctl.stop();
    chk("busy_pre", {7'h0, busy}, 8'h01);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("rst_mid", {5'h0, stby, busy, oe}, 8'h04);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    u_ctl.start();
    wb(8'ha0, 1'b1);
    u_ctl.stop();
    test_done();
  end
endmodule : eep_target_bench
`default_nettype wire

// [hw/eep_defs.svh]
`ifndef EEP_DEFS_SVH
`define EEP_DEFS_SVH

// device type codes in address byte bits 7..4
`define EEP_ARRAY_CODE 4'ha
`define EEP_IDPAGE_CODE 4'hb

// address byte field positions
`define EEP_AB_CODE_HI 7
`define EEP_AB_CODE_LO 4
`define EEP_AB_STRAP_HI 3
`define EEP_AB_STRAP_LO 2
`define EEP_AB_BLOCK 1
`define EEP_AB_RW 0

// reset values
`define EEP_PTR_RST 9'h000
`define EEP_MASK_RST 16'h0000

// self-timed programming time and system clock rate
`define EEP_TWR_US 4000
`define EEP_CLK_MHZ 125

`endif

// [hw/eep_pkg.sv]
package eep_pkg;

  // bus sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WADR,
    ST_WACK,
    ST_WDAT,
    ST_DACK,
    ST_RDAT,
    ST_RACK
  } eep_state_t;

endpackage : eep_pkg

// [hw/eep_target.sv]
`timescale 1ns/1ps
`default_nettype none
`include "eep_defs.svh"

module eep_target #(
  parameter int MEM_BYTES = 512,
  parameter int PAGE_BYTES = 16,
  parameter int WR_CYCLES = `EEP_TWR_US * `EEP_CLK_MHZ
) (
  input  wire logic SYS_CLK,
  input  wire logic RST,
  input  wire logic SCL,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE,
  input  wire logic WP,
  input  wire logic ADDRESS_STRAP_LOW,
  input  wire logic ADDRESS_STRAP_HIGH,
  output logic      STANDBY,
  output logic      WRITE_BUSY
);

  localparam int CW = $clog2(WR_CYCLES + 1);

  eep_pkg::eep_state_t state_reg;
  logic [4:0]          sync1_reg;
  logic [4:0]          sync2_reg;
  logic                scl_prev_reg;
  logic                sda_prev_reg;
  logic                scl_s;
  logic                sda_s;
  logic                wp_s;
  logic [1:0]          strap_s;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic [3:0]          bit_cnt_reg;
  logic [7:0]          rx_reg;
  logic [7:0]          tx_reg;
  logic                rw_reg;
  logic                id_sel_reg;
  logic                ack_ok_reg;
  logic [8:0]          ptr_reg;
  logic [15:0]         mask_reg;
  logic                busy_reg;
  logic [CW-1:0]       busy_cnt_reg;
  logic                addr_hit;
  logic                commit;
  logic                byte_done;
  logic [7:0]          mem [MEM_BYTES];
  logic [7:0]          id_mem [PAGE_BYTES];
  logic [7:0]          page_buf [PAGE_BYTES];

  // two-flop synchronisers for the bus, write-protect and strap pins
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1_reg <= 5'h1f;
      sync2_reg <= 5'h1f;
    end
    else
    begin
      sync1_reg <= {ADDRESS_STRAP_HIGH, ADDRESS_STRAP_LOW, WP, SDA_IN, SCL};
      sync2_reg <= sync1_reg;
    end
  end

  assign scl_s   = sync2_reg[0];
  assign sda_s   = sync2_reg[1];
  assign wp_s    = sync2_reg[2];
  assign strap_s = sync2_reg[4:3];

  // previous samples for edge detection, idle bus is high
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_reg;
  assign scl_fall  = ~scl_s & scl_prev_reg;
  // data edges while clock stays high are bus conditions
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign byte_done = scl_fall & (bit_cnt_reg == 4'h8);

  // type code, straps; polling sees no ack since busy holds the sequencer idle
  assign addr_hit = ((rx_reg[`EEP_AB_CODE_HI:`EEP_AB_CODE_LO] == `EEP_ARRAY_CODE)
                    | (rx_reg[`EEP_AB_CODE_HI:`EEP_AB_CODE_LO] == `EEP_IDPAGE_CODE))
                    & (rx_reg[`EEP_AB_STRAP_HI:`EEP_AB_STRAP_LO] == strap_s);

  // program only with buffered bytes and write-protect low
  assign commit = stop_det & (mask_reg != `EEP_MASK_RST) & ~wp_s & ~busy_reg;

  // open drain: only ever pull low
  assign SDA_OUT    = 1'b0;
  assign WRITE_BUSY = busy_reg;
  assign STANDBY    = (state_reg == eep_pkg::ST_IDLE) & ~busy_reg;

  // bus sequencer; a start restarts it from any state unless busy
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg   <= eep_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      SDA_OE      <= 1'b0;
      rw_reg      <= 1'b0;
      id_sel_reg  <= 1'b0;
      ack_ok_reg  <= 1'b0;
    end
    else if (busy_reg)
    begin
      state_reg <= eep_pkg::ST_IDLE;
      SDA_OE    <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg   <= eep_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
      SDA_OE      <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= eep_pkg::ST_IDLE;
      SDA_OE    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        eep_pkg::ST_IDLE:
        begin
          SDA_OE <= 1'b0;
        end
        eep_pkg::ST_ADDR, eep_pkg::ST_WADR, eep_pkg::ST_WDAT:
        begin
          // bits taken on clock rise, decided on eighth fall
          if (scl_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done)
          begin
            if (state_reg == eep_pkg::ST_ADDR)
            begin
              if (addr_hit)
              begin
                SDA_OE     <= 1'b1;
                rw_reg     <= rx_reg[`EEP_AB_RW];
                id_sel_reg <= rx_reg[`EEP_AB_CODE_LO];
                state_reg  <= eep_pkg::ST_AACK;
              end
              else
              begin
                state_reg <= eep_pkg::ST_IDLE;
              end
            end
            else if (state_reg == eep_pkg::ST_WADR)
            begin
              SDA_OE    <= 1'b1;
              state_reg <= eep_pkg::ST_WACK;
            end
            else
            begin
              SDA_OE    <= 1'b1;
              state_reg <= eep_pkg::ST_DACK;
            end
          end
        end
        eep_pkg::ST_AACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              SDA_OE    <= ~tx_reg[7];
              state_reg <= eep_pkg::ST_RDAT;
            end
            else
            begin
              SDA_OE    <= 1'b0;
              state_reg <= eep_pkg::ST_WADR;
            end
          end
        end
        eep_pkg::ST_WACK, eep_pkg::ST_DACK:
        begin
          if (scl_fall)
          begin
            SDA_OE      <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= eep_pkg::ST_WDAT;
          end
        end
        eep_pkg::ST_RDAT:
        begin
          // first bit went out at the ack fall, seven more follow
          if (scl_fall)
          begin
            if (bit_cnt_reg == 4'h7)
            begin
              SDA_OE    <= 1'b0;
              state_reg <= eep_pkg::ST_RACK;
            end
            else
            begin
              SDA_OE      <= ~tx_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        eep_pkg::ST_RACK:
        begin
          if (scl_rise)
          begin
            ack_ok_reg <= ~sda_s;
          end
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            if (ack_ok_reg)
            begin
              SDA_OE    <= ~tx_reg[7];
              state_reg <= eep_pkg::ST_RDAT;
            end
            else
            begin
              state_reg <= eep_pkg::ST_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= eep_pkg::ST_IDLE;
          SDA_OE    <= 1'b0;
        end
      endcase
    end
  end

  // receive shift register
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_reg <= 8'h00;
    end
    else if (scl_rise)
    begin
      rx_reg <= {rx_reg[6:0], sda_s};
    end
  end

  // address counter: block bit, word address, page or full wrap
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      ptr_reg <= `EEP_PTR_RST;
    end
    else if (!busy_reg && !start_det && !stop_det)
    begin
      if (state_reg == eep_pkg::ST_ADDR && byte_done && addr_hit)
      begin
        ptr_reg[8] <= rx_reg[`EEP_AB_BLOCK];
      end
      else if (state_reg == eep_pkg::ST_WADR && byte_done)
      begin
        ptr_reg[7:0] <= rx_reg;
      end
      else if (state_reg == eep_pkg::ST_WDAT && byte_done)
      begin
        ptr_reg[3:0] <= ptr_reg[3:0] + 4'h1;
      end
      else if (state_reg == eep_pkg::ST_RDAT && scl_fall && bit_cnt_reg == 4'h7)
      begin
        ptr_reg <= ptr_reg + 9'h001;
      end
    end
  end

  // transmit byte reloaded on every clock of the ack bit, shifted per bit
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_reg <= 8'h00;
    end
    else if (state_reg == eep_pkg::ST_AACK || state_reg == eep_pkg::ST_RACK)
    begin
      tx_reg <= id_sel_reg ? id_mem[ptr_reg[3:0]] : mem[ptr_reg];
    end
    else if (state_reg == eep_pkg::ST_RDAT && scl_fall)
    begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // page buffer; a start or stop discards unfinished data
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      mask_reg <= `EEP_MASK_RST;
    end
    else if (start_det || stop_det || busy_reg)
    begin
      mask_reg <= `EEP_MASK_RST;
    end
    else if (state_reg == eep_pkg::ST_WDAT && byte_done)
    begin
      mask_reg[ptr_reg[3:0]] <= 1'b1;
    end
  end

  // later bytes at a wrapped position overwrite earlier ones
  always_ff @(posedge SYS_CLK)
  begin
    if (state_reg == eep_pkg::ST_WDAT && byte_done && !start_det && !stop_det)
    begin
      page_buf[ptr_reg[3:0]] <= rx_reg;
    end
  end

  // buffered bytes of the page land in one clock; one write port per page slot
  always_ff @(posedge SYS_CLK)
  begin
    for (int i = 0; i < PAGE_BYTES; i++)
    begin
      if (commit && mask_reg[i])
      begin
        if (id_sel_reg)
        begin
          id_mem[i] <= page_buf[i];
        end
        else
        begin
          mem[{ptr_reg[8:4], 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // self-timed programming; bus, write-protect and straps are ignored meanwhile, reset still ends it
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end
    else if (commit)
    begin
      busy_reg     <= 1'b1;
      busy_cnt_reg <= CW'(WR_CYCLES - 1);
    end
    else if (busy_reg)
    begin
      if (busy_cnt_reg == '0)
      begin
        busy_reg <= 1'b0;
      end
      else
      begin
        busy_cnt_reg <= busy_cnt_reg - 1'b1;
      end
    end
  end

  AST_IDLE_HOLDS:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_reg == eep_pkg::ST_IDLE && !start_det) |=> state_reg == eep_pkg::ST_IDLE)
  else $error("left idle without a start");

  AST_STOP_ENDS:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    stop_det |=> (state_reg == eep_pkg::ST_IDLE && !SDA_OE))
  else $error("stop did not end transaction");

  AST_START_RESETS:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (start_det && !busy_reg) |=> (state_reg == eep_pkg::ST_ADDR && bit_cnt_reg == 4'h0
                                  && mask_reg == 16'h0000))
  else $error("start did not reset bus logic");

  AST_ACK_ONLY_ON_HIT:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_reg == eep_pkg::ST_ADDR && byte_done && !start_det && !stop_det && !busy_reg)
    |=> (SDA_OE == $past(addr_hit)))
  else $error("address ack does not follow match");

  AST_BUSY_SILENT:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    busy_reg |=> !SDA_OE)
  else $error("device drove data while programming");

  AST_PROTECT_BLOCKS:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (stop_det && wp_s && !busy_reg) |=> !busy_reg)
  else $error("programming started under write protect");

  AST_COMMIT_STARTS:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    commit |=> busy_reg [*8])
  else $error("programming cycle too short");

  AST_PAGE_FIXED:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_reg == eep_pkg::ST_WDAT && $past(state_reg) == eep_pkg::ST_WDAT)
    |-> ptr_reg[8:4] == $past(ptr_reg[8:4]))
  else $error("high address bits moved in page");

  AST_READ_DIR:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_reg == eep_pkg::ST_AACK && scl_fall && rw_reg && !start_det && !stop_det)
    |=> state_reg == eep_pkg::ST_RDAT)
  else $error("read direction not honoured");

endmodule : eep_target

`default_nettype wire
